/* seq_decode_pkg.sv */
// constants for the sequencer instruction decoder: register map, fields, codes
// assumes a 32-bit ahb-lite bus and a 16-bit instruction word
package seq_decode_pkg;

  // register byte offsets
  localparam logic [7:0]  OFS_INSTR  = 8'h00;
  localparam logic [7:0]  OFS_STATUS = 8'h04;
  localparam logic [7:0]  OFS_FETCH  = 8'h08;
  localparam logic [7:0]  OFS_FLAGS  = 8'h0C;
  localparam logic [7:0]  OFS_CNT    = 8'h10;
  localparam logic [7:0]  OFS_CNT_END = 8'h20;

  // instruction word fields
  localparam int          BIT_CLASS = 15;
  localparam int          OPC_HI    = 14;
  localparam int          OPC_LO    = 12;
  localparam int          ARG_HI    = 11;
  localparam int          POL_BIT   = 11;
  localparam int          ADR_HI    = 10;
  localparam int          ADR_LO    = 6;
  localparam int          TMP_HI    = 5;
  localparam int          TMP_LO    = 4;
  localparam int          SKP_HI    = 3;

  // internal control operation codes
  localparam logic [2:0]  CTL_NOP   = 3'h0;
  localparam logic [2:0]  CTL_LC1   = 3'h1;
  localparam logic [2:0]  CTL_LC4   = 3'h4;
  localparam logic [2:0]  CTL_JUMP  = 3'h5;
  localparam logic [2:0]  CTL_CALL  = 3'h6;

  // logical operation codes
  localparam logic [2:0]  LOG_LOAD  = 3'h0;
  localparam logic [2:0]  LOG_AND   = 3'h1;
  localparam logic [2:0]  LOG_OR    = 3'h2;
  localparam logic [2:0]  LOG_XOR   = 3'h3;
  localparam logic [2:0]  LOG_STORE = 3'h6;
  localparam logic [2:0]  LOG_FORCE = 3'h7;

  // operand address map
  localparam logic [4:0]  ADR_PINS  = 5'h00;
  localparam logic [4:0]  ADR_CNTZ  = 5'h0C;
  localparam logic [4:0]  ADR_MEM   = 5'h10;
  localparam logic [4:0]  ADR_TEMP  = 5'h1C;
  localparam logic [4:0]  CNT_PINS  = 5'h0C;
  localparam logic [4:0]  CNT_CNTZ  = 5'h04;
  localparam logic [4:0]  CNT_MEM   = 5'h0C;
  localparam logic [4:0]  CNT_TEMP  = 5'h03;

  // values and timing
  localparam logic [11:0] RETURN_ARG = 12'hFFF;
  localparam logic [11:0] CNT_RESET  = 12'hFFF;
  localparam logic [11:0] PC_STEP    = 12'h002;
  localparam logic [1:0]  SHIFT_LAST = 2'h3;   // four oscillator periods per shift clock
  localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;

endpackage

/* bool_unit.sv */
// one-bit logic unit: combines the accumulator with an operand bit
// assumes operand already steered by the caller; purely combinational
`timescale 1ns/100ps
module bool_unit
(
  // operation
  input  wire logic [2:0] op,
  input  wire logic       polarity,
  // operands
  input  wire logic       acc,
  input  wire logic       operand,
  // result
  output logic            result
);

  logic       sel_bit;

  // true value on 0, complement on 1
  assign sel_bit = operand ^ polarity;

  // result of each operation; unlisted codes pass the accumulator
  assign result = (op == seq_decode_pkg::LOG_LOAD)  ? sel_bit :
                  (op == seq_decode_pkg::LOG_AND)   ? acc & sel_bit :
                  (op == seq_decode_pkg::LOG_OR)    ? acc | sel_bit :
                  (op == seq_decode_pkg::LOG_XOR)   ? acc ^ sel_bit :
                  (op == seq_decode_pkg::LOG_STORE) ? acc ^ polarity :
                  (op == seq_decode_pkg::LOG_FORCE) ? ~polarity :
                  acc;

endmodule // bool_unit

/* sequencer_instruction_decode.sv */
// decode and execute of the 16-bit sequencer instruction word, with ahb-lite register access
// assumes one 100 MHz clock standing in for the oscillator; the serial fetch is outside
// assumes software writes each fetched instruction word over the bus, one at a time
//
// The placing of the registers and the AHB-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/100ps
module sequencer_instruction_decode #(
  parameter int N_PINS = 12,
  parameter int CNT_W  = 12
)
(
  // clock and reset
  input  wire logic              hclk,
  input  wire logic              hresetn,
  // ahb-lite slave
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic      [31:0]       hrdata,
  output logic                   hreadyout,
  output logic                   hresp,
  // pins
  input  wire logic [N_PINS-1:0] sensed_pins,
  output logic      [N_PINS-1:0] latched_outputs,
  output logic                   shift_clock,
  output logic                   exec_strobe
);

  // pin synchroniser
  logic [N_PINS-1:0] sense_meta_ff;
  logic [N_PINS-1:0] sense_ff;
  // timing
  logic [1:0]        div_ff;
  logic              pending_ff;
  logic              exec_ff;
  // program state
  logic [15:0]       instr_ff;
  logic [11:0]       fetch_pointer_ff;
  logic [11:0]       stack0_ff;
  logic [11:0]       stack1_ff;
  logic [CNT_W-1:0]  down_counter_ff [4];
  logic              accumulator_bit_ff;
  logic [2:0]        temp_ff;
  logic [11:0]       mem_ff;
  logic [N_PINS-1:0] latched_outputs_ff;
  // bus state
  logic              ap_valid_ff;
  logic              ap_write_ff;
  logic [7:0]        ap_addr_ff;
  logic [31:0]       hrdata_ff;

  // address window test, used by both operand maps
  // upper bound one bit wider, so a window ending at 11111 does not wrap
  function automatic logic in_span(input logic [4:0] a, input logic [4:0] base, input logic [4:0] n);
    logic [5:0] top;
    top     = {1'b0, base} + {1'b0, n};
    in_span = (a >= base) && ({1'b0, a} < top);
  endfunction

  // instruction fields
  // one op field for both classes; the class bit decides how the rest is read
  wire        is_logic   = instr_ff[seq_decode_pkg::BIT_CLASS];
  wire [2:0]  opc        = instr_ff[seq_decode_pkg::OPC_HI:seq_decode_pkg::OPC_LO];
  wire [11:0] arg_n      = instr_ff[seq_decode_pkg::ARG_HI:0];
  wire        polarity   = instr_ff[seq_decode_pkg::POL_BIT];
  wire [4:0]  radr       = instr_ff[seq_decode_pkg::ADR_HI:seq_decode_pkg::ADR_LO];
  wire [1:0]  tsel       = instr_ff[seq_decode_pkg::TMP_HI:seq_decode_pkg::TMP_LO];
  wire [3:0]  branch_offset = instr_ff[seq_decode_pkg::SKP_HI:0];

  // counter zero flags, live from the counters
  // a decrement to zero is visible to the very next instruction
  logic [3:0] cnt_zero;
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_zero
      assign cnt_zero[gi] = (down_counter_ff[gi] == '0);
    end
  endgenerate

  // input operand steering
  wire in_pins = in_span(radr, seq_decode_pkg::ADR_PINS, seq_decode_pkg::CNT_PINS);
  wire in_cntz = in_span(radr, seq_decode_pkg::ADR_CNTZ, seq_decode_pkg::CNT_CNTZ);
  wire in_mem  = in_span(radr, seq_decode_pkg::ADR_MEM, seq_decode_pkg::CNT_MEM);
  wire in_temp = in_span(radr, seq_decode_pkg::ADR_TEMP, seq_decode_pkg::CNT_TEMP);
  wire in_ok   = in_pins | in_cntz | in_mem | in_temp;
  // index inside each window; every window starts on a multiple of four
  wire [3:0] pin_idx  = radr[3:0];
  wire [1:0] cntz_idx = radr[1:0];
  wire [3:0] mem_idx  = radr[3:0];
  wire [1:0] temp_idx = radr[1:0];
  // an unassigned address reads zero here, and in_ok keeps it from acting
  wire operand = in_pins ? sense_ff[pin_idx] :
                 in_cntz ? cnt_zero[cntz_idx] :
                 in_mem  ? mem_ff[mem_idx] :
                 in_temp ? temp_ff[temp_idx] : 1'b0;

  // output target steering
  // no counter or temp window on the output side
  wire out_lo  = in_span(radr, seq_decode_pkg::ADR_PINS, seq_decode_pkg::CNT_PINS);
  wire out_ok  = out_lo | in_mem;

  // operation classes
  // logical ops 100 and 101 fall in neither class and act as no-ops
  wire is_input_op  = is_logic && (opc <= seq_decode_pkg::LOG_XOR);
  wire is_output_op = is_logic && (opc >= seq_decode_pkg::LOG_STORE);
  wire op_valid     = (is_input_op && in_ok) || (is_output_op && out_ok);
  wire is_cnt_op    = !is_logic && (opc >= seq_decode_pkg::CTL_LC1) && (opc <= seq_decode_pkg::CTL_LC4);
  wire [1:0] cnt_sel = 2'(opc - seq_decode_pkg::CTL_LC1);
  wire is_jump      = !is_logic && (opc == seq_decode_pkg::CTL_JUMP);
  wire is_return    = is_jump && (arg_n == seq_decode_pkg::RETURN_ARG);
  wire is_call      = !is_logic && (opc == seq_decode_pkg::CTL_CALL);

  // logic unit
  // its result also feeds the temps and the skip test
  logic lu_result;
  bool_unit u_bool_unit
  (
    .op       (opc),
    .polarity (polarity),
    .acc      (accumulator_bit_ff),
    .operand  (operand),
    .result   (lu_result)
  );

  // next pointer; the step is taken before the offset, so offsets count from the next word
  wire [11:0] pc_next_seq = fetch_pointer_ff + seq_decode_pkg::PC_STEP;
  wire [11:0] pc_offset   = {{7{branch_offset[3]}}, branch_offset, 1'b0};
  wire        take_skip   = is_logic && op_valid && (branch_offset != 4'h0) && !lu_result;
  wire [11:0] skip_target = 12'(pc_next_seq + pc_offset);
  // return first: an all-ones operand is never a jump target
  wire [11:0] nxt_pc = is_return ? stack0_ff :
                       (is_jump || is_call) ? arg_n :
                       take_skip ? skip_target :
                       pc_next_seq;

  // shift clock divider: one tick every four oscillator periods
  wire shift_tick = (div_ff == seq_decode_pkg::SHIFT_LAST);
  assign shift_clock = div_ff[1];
  assign exec_strobe = exec_ff;

  // free-running: the fetch it paces never pauses
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      div_ff <= 2'h0;
    else
      div_ff <= 2'(div_ff + 2'h1);
  end

  // pin inputs cross two flops before any use
  // the first flop may go metastable, so only the second is read
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sense_meta_ff <= '0;
      sense_ff      <= '0;
    end
    else
    begin
      sense_meta_ff <= sensed_pins;
      sense_ff      <= sense_meta_ff;
    end
  end

  // bus decode
  // only the low address byte is decoded; the map repeats above it
  wire        ap_take   = hsel && hready && (htrans == seq_decode_pkg::HTRANS_NONSEQ);
  wire [7:0]  ap_addr   = haddr[7:0];
  wire        dp_write  = ap_valid_ff && ap_write_ff;
  wire        busy      = pending_ff || exec_ff;
  wire        dp_prog   = dp_write && ((ap_addr_ff == seq_decode_pkg::OFS_INSTR) ||
                                       (ap_addr_ff == seq_decode_pkg::OFS_FETCH));
  // a program write waits out a running instruction rather than corrupt it
  wire        stall     = dp_prog && busy;
  wire        wr_instr  = dp_write && !busy && (ap_addr_ff == seq_decode_pkg::OFS_INSTR);
  wire        wr_fetch  = dp_write && !busy && (ap_addr_ff == seq_decode_pkg::OFS_FETCH);
  // reads and other writes never wait; only a program write holds the bus
  assign hreadyout = !stall;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_ff;

  // read data, chosen at the address phase so it stands in the data phase
  // a change after the address phase shows on the next read
  wire [1:0]  cnt_rd_idx  = ap_addr[3:2];  // counters sit one word apart
  wire [31:0] status_word = {20'h00000, cnt_zero, temp_ff, accumulator_bit_ff, 3'h0, busy};
  wire [31:0] flags_word  = {4'h0, mem_ff, 4'h0, 12'(latched_outputs_ff)};
  wire        rd_cnt      = (ap_addr >= seq_decode_pkg::OFS_CNT) && (ap_addr < seq_decode_pkg::OFS_CNT_END);
  wire [31:0] rd_value    = (ap_addr == seq_decode_pkg::OFS_INSTR)  ? {16'h0000, instr_ff} :
                            (ap_addr == seq_decode_pkg::OFS_STATUS) ? status_word :
                            (ap_addr == seq_decode_pkg::OFS_FETCH)  ? {20'h00000, fetch_pointer_ff} :
                            (ap_addr == seq_decode_pkg::OFS_FLAGS)  ? flags_word :
                            rd_cnt ? 32'(down_counter_ff[cnt_rd_idx]) : 32'h00000000;

  // bus address phase capture
  // held through a stall so the waiting write keeps its own address
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ap_valid_ff <= 1'b0;
      ap_write_ff <= 1'b0;
      ap_addr_ff  <= 8'h00;
      hrdata_ff   <= 32'h00000000;
    end
    else if (!stall)
    begin
      ap_valid_ff <= ap_take;
      ap_write_ff <= hwrite;
      ap_addr_ff  <= ap_addr;
      hrdata_ff   <= (ap_take && !hwrite) ? rd_value : hrdata_ff;
    end
  end

  // instruction hand-off: wait for the shift tick, execute one period after it
  // only one word can wait; a second program write stalls on busy
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      instr_ff   <= 16'h0000;
      pending_ff <= 1'b0;
      exec_ff    <= 1'b0;
    end
    else
    begin
      if (wr_instr)
        instr_ff <= hwdata[15:0];
      pending_ff <= wr_instr || (pending_ff && !shift_tick);
      exec_ff    <= pending_ff && shift_tick;
    end
  end

  // fetch pointer and two-level return stack
  // a pop leaves the lower entry in place, so two returns land on one address
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      fetch_pointer_ff <= 12'h000;
      stack0_ff        <= 12'h000;
      stack1_ff        <= 12'h000;
    end
    else if (wr_fetch)
      fetch_pointer_ff <= hwdata[11:0];
    else if (exec_ff)
    begin
      fetch_pointer_ff <= nxt_pc;
      if (is_return)
        stack0_ff <= stack1_ff;
      else if (is_call)
      begin
        stack1_ff <= stack0_ff;
        stack0_ff <= pc_next_seq;
      end
    end
  end

  // down-counters: load, or decrement on a zero operand
  // a decrement from zero wraps to all ones, as a hardware down-counter does
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_cnt
      wire hit = exec_ff && is_cnt_op && (cnt_sel == 2'(gi));
      always_ff @(posedge hclk or negedge hresetn)
      begin
        if (!hresetn)
          down_counter_ff[gi] <= CNT_W'(seq_decode_pkg::CNT_RESET);
        else if (hit && (arg_n == 12'h000))
          down_counter_ff[gi] <= CNT_W'(down_counter_ff[gi] - 1'b1);
        else if (hit)
          down_counter_ff[gi] <= CNT_W'(arg_n);
      end
    end
  endgenerate

  // accumulator and temporary flags, only for assigned addresses
  // temps take the result of valid input and output operations alike
  wire do_input = exec_ff && is_input_op && in_ok;
  wire do_temp  = exec_ff && op_valid && (tsel != 2'h0);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      accumulator_bit_ff <= 1'b0;
      temp_ff            <= 3'h0;
    end
    else
    begin
      if (do_input)
        accumulator_bit_ff <= lu_result;
      if (do_temp)
        temp_ff[2'(tsel - 2'h1)] <= lu_result;
    end
  end

  // output latches and memory flags
  // one write port: out_lo picks the latches, otherwise the memory flags
  wire do_output = exec_ff && is_output_op && out_ok;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      latched_outputs_ff <= '0;
      mem_ff             <= 12'h000;
    end
    else if (do_output && out_lo)
      latched_outputs_ff[pin_idx] <= lu_result;
    else if (do_output)
      mem_ff[mem_idx] <= lu_result;
  end

  // pins come straight from the latch flops, free of decode glitches
  assign latched_outputs = latched_outputs_ff;

endmodule // sequencer_instruction_decode

/* sequencer_instruction_decode_props.sv */
// concurrent checks on the sequencer decoder's top-level ports
// assumes one clock domain, hready tied back to hreadyout by the bench
`timescale 1ns/100ps
module sequencer_instruction_decode_props #(
  parameter int N_PINS = 12,
  parameter int CNT_W  = 12
)
(
  // clock and reset
  input wire logic              hclk,
  input wire logic              hresetn,
  // ahb-lite slave
  input wire logic              hsel,
  input wire logic [31:0]       haddr,
  input wire logic [1:0]        htrans,
  input wire logic              hwrite,
  input wire logic [2:0]        hsize,
  input wire logic [31:0]       hwdata,
  input wire logic              hready,
  input wire logic [31:0]       hrdata,
  input wire logic              hreadyout,
  input wire logic              hresp,
  // pins
  input wire logic [N_PINS-1:0] sensed_pins,
  input wire logic [N_PINS-1:0] latched_outputs,
  input wire logic              shift_clock,
  input wire logic              exec_strobe
);
  logic [1:0] pend_ff;
  logic [1:0] nxt_pend;
  // taken address phases, decoded once for all checks
  wire take    = hsel & hready & (htrans == seq_decode_pkg::HTRANS_NONSEQ);
  wire rd_take = take & !hwrite;
  wire wr_ins  = take & hwrite & (haddr[7:0] == seq_decode_pkg::OFS_INSTR);
  wire rd_flg  = rd_take & (haddr[7:0] == seq_decode_pkg::OFS_FLAGS);
  // queued instructions not yet executed; an execute with none queued is spurious
  assign nxt_pend = pend_ff + {1'b0, wr_ins} - {1'b0, exec_strobe};
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      pend_ff <= 2'h0;
    else
      pend_ff <= nxt_pend;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  chk_shift_period: assert property ($rose(shift_clock) |=> shift_clock ##1 !shift_clock ##1 !shift_clock ##1 shift_clock)
    else $error("shift clock period is not four cycles");
  chk_exec_pulse: assert property (exec_strobe |=> !exec_strobe [*3])
    else $error("execute pulses closer than one shift period");
  chk_exec_edge: assert property (exec_strobe |-> shift_clock != $past(shift_clock))
    else $error("execute not one cycle after a shift clock edge");
  chk_latch_cause: assert property (!$stable(latched_outputs) |-> $past(exec_strobe))
    else $error("latched outputs moved without an execute");
  chk_stall_bound: assert property ($fell(hreadyout) |-> ##[1:8] hreadyout)
    else $error("bus stall too long");
  chk_read_nowait: assert property (rd_take |=> hreadyout)
    else $error("read inserted wait states");
  chk_flags_echo: assert property (rd_flg && !exec_strobe |=> hrdata[11:0] == latched_outputs)
    else $error("flags readback differs from latched outputs");
  chk_exec_cause: assert property (exec_strobe |-> pend_ff != 2'h0)
    else $error("execute without a queued instruction");

  // main scenarios reached
  cover property (exec_strobe);
  cover property ($fell(hreadyout));
  cover property (!$stable(latched_outputs));
endmodule // sequencer_instruction_decode_props

bind sequencer_instruction_decode sequencer_instruction_decode_props #(.N_PINS(N_PINS), .CNT_W(CNT_W)) u_props (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .sensed_pins(sensed_pins), .latched_outputs(latched_outputs), .shift_clock(shift_clock),
  .exec_strobe(exec_strobe));

/* prog_memory.sv */
// byte-wide program memory feeding instruction words to the bench
// assumes the bench loads it before fetching; no timing of its own on fetch
`timescale 1ns/100ps
module prog_memory
(
  // load side
  input  wire logic        clk,
  input  wire logic        load_en,
  input  wire logic [11:0] load_addr,
  input  wire logic [7:0]  load_byte,
  // fetch side
  input  wire logic [11:0] fetch_addr,
  output logic      [15:0] fetch_word
);
  logic [7:0] bytes_ff [4096];
  // one byte per location
  always_ff @(posedge clk)
    if (load_en)
      bytes_ff[load_addr] <= load_byte;
  // low byte at the even address, high byte at the next one
  assign fetch_word = {bytes_ff[fetch_addr + 12'h001], bytes_ff[fetch_addr]};
endmodule // prog_memory

/* sequencer_instruction_decode_test.sv */
// self-checking bench: runs a program from memory through the decoder over ahb-lite
// assumes reads answer after the data phase once hreadyout is high
`timescale 1ns/100ps
module sequencer_instruction_decode_test;
  logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, rd_ph = 1'b0, acc = 1'b0, load_en = 1'b0;
  logic [31:0] haddr = '0, hwdata = '0, hrdata;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2, tm = 3'h0;
  logic [11:0] pins = '0, fp = '0, st0 = '0, st1 = '0, mf = '0, lo = '0, load_addr = '0, nv, latched_outputs;
  logic [11:0] cn [4] = '{12'hFFF, 12'hFFF, 12'hFFF, 12'hFFF};
  logic [7:0]  load_byte = '0;
  logic [15:0] fetch_word, w;
  logic        hreadyout, hresp, shift_clock, exec_strobe;
  logic [63:0] exp_q [$];
  int          err_count = 0, comparisons = 0, exec_cnt = 0, tgt = 0, cyc = 0;
  localparam logic [15:0] DIR [7] = '{16'h1000, 16'h4005, 16'h600C, 16'hFFC0, 16'hF000, 16'hB331, 16'h5FFF};

  sequencer_instruction_decode u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .sensed_pins(pins), .latched_outputs(latched_outputs), .shift_clock(shift_clock),
    .exec_strobe(exec_strobe));
  prog_memory u_mem (.clk(hclk), .load_en(load_en), .load_addr(load_addr), .load_byte(load_byte),
    .fetch_addr(fp), .fetch_word(fetch_word));

  always #5 hclk = ~hclk;

  task final_report();
    $display("comparisons %0d errors %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // result watcher: oldest note against read data; also counts executes and cuts hangs
  always @(posedge hclk)
  begin
    logic [63:0] e;
    cyc = cyc + 1;
    if (exec_strobe === 1'b1) exec_cnt = exec_cnt + 1;
    if (rd_ph && hreadyout === 1'b1)
    begin
      e = exp_q.pop_front();
      comparisons = comparisons + 1;
      if ((hrdata & e[63:32]) !== e[31:0])
      begin
        err_count = err_count + 1;
        $display("ERROR %0t read %h expected %h", $time, hrdata & e[63:32], e[31:0]);
      end
      comparisons = comparisons + 1;
      if (hresp !== 1'b0)
      begin
        err_count = err_count + 1;
        $display("ERROR %0t error response on read", $time);
      end
    end
    if (cyc == 30000)
    begin
      err_count = err_count + 1;
      $display("ERROR %0t timeout", $time);
      final_report();
    end
  end

  // one bus transfer: address phase held until ready, then data phase until ready
  task xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= wr;
    htrans <= seq_decode_pkg::HTRANS_NONSEQ;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    rd_ph <= !wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd_ph <= 1'b0;
  endtask

  task rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    exp_q.push_back({m, e});
    xfer(1'b0, a, 32'h0);
  endtask

  // reference behaviour of one instruction word
  task model(input logic [15:0] iw);
    logic [2:0]  op;
    logic [4:0]  a;
    logic        v, r, ok;
    logic [11:0] nfp;
    op = iw[14:12];
    a = iw[10:6];
    nfp = fp + 12'h002;
    ok = 1'b0;
    r = 1'b0;
    if (!iw[15])
    begin
      if (op != 3'h0 && op < 3'h5) cn[op-3'h1] = (iw[11:0] == 12'h000) ? cn[op-3'h1] - 12'h001 : iw[11:0];
      if (op == 3'h5) {nfp, st0} = (iw[11:0] == 12'hFFF) ? {st0, st1} : {iw[11:0], st0};
      if (op == 3'h6) st1 = st0;
      if (op == 3'h6) st0 = nfp;
      if (op == 3'h6) nfp = iw[11:0];
    end
    else
    begin
      if (op < 3'h4)
      begin
        ok = (a != 5'h1F);
        v = ((a < 5'h0C) ? pins[a[3:0]] : (a < 5'h10) ? (cn[a[1:0]] == 12'h000) :
             (a < 5'h1C) ? mf[a[3:0]] : tm[a[1:0]]) ^ iw[11];
        case (op)
          3'h0: r = v;
          3'h1: r = acc & v;
          3'h2: r = acc | v;
          default: r = acc ^ v;
        endcase
        if (ok) acc = r;
      end
      if (op > 3'h5)
      begin
        r = (op == 3'h6) ? acc ^ iw[11] : ~iw[11];
        ok = (a < 5'h0C) || (a >= 5'h10 && a < 5'h1C);
        if (ok && !a[4]) lo[a[3:0]] = r;
        if (ok && a[4]) mf[a[3:0]] = r;
      end
      if (ok && iw[5:4] != 2'h0) tm[iw[5:4]-2'h1] = r;
      if (ok && iw[3:0] != 4'h0 && !r) nfp = nfp + {{7{iw[3]}}, iw[3:0], 1'b0};
    end
    fp = nfp;
  endtask

  // fetch the word at the pointer, hand it to the decoder, note its effect
  task step();
    w = fetch_word;
    xfer(1'b1, seq_decode_pkg::OFS_INSTR, {16'h0, w});
    model(w);
    tgt = tgt + 1;
  endtask

  // wait for every queued execute, then read back status, fetch pointer, flags and counters, and check the output pins
  task check();
    while (exec_cnt < tgt) @(posedge hclk);
    @(posedge hclk);
    rd(seq_decode_pkg::OFS_STATUS, {20'h0, cn[3] == 12'h0, cn[2] == 12'h0, cn[1] == 12'h0, cn[0] == 12'h0,
       tm, acc, 4'h0}, 32'h0000_0FF1);
    rd(seq_decode_pkg::OFS_FETCH, {20'h0, fp}, 32'h0000_0FFF);
    rd(seq_decode_pkg::OFS_FLAGS, {4'h0, mf, 4'h0, lo}, 32'h0FFF_0FFF);
    for (int k = 0; k < 4; k++) rd(seq_decode_pkg::OFS_CNT + 8'(4 * k), {20'h0, cn[k]}, 32'h0000_0FFF);
    comparisons = comparisons + 1;
    if (latched_outputs !== lo)
    begin
      err_count = err_count + 1;
      $display("ERROR %0t latched outputs %h expected %h", $time, latched_outputs, lo);
    end
    pins <= 12'($urandom);
    @(posedge hclk);
  endtask

  // main sequence: reset, load program, run it, then register odds and ends
  initial
  begin
    void'($urandom(64291));
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    for (int i = 0; i < 4096; i++)
    begin
      load_en <= 1'b1;
      load_addr <= 12'(i);
      load_byte <= (i < 14) ? DIR[i / 2][8 * (i % 2) +: 8] : 8'($urandom);
      @(posedge hclk);
    end
    load_en <= 1'b0;
    @(posedge hclk);
    check();
    for (int i = 0; i < 80; i++)
    begin
      if (i == 40)
      begin
        nv = 12'($urandom) & 12'hFFE;
        xfer(1'b1, seq_decode_pkg::OFS_FETCH, {20'h0, nv});
        fp = nv;
      end
      step();
      if (i % 4 != 1) check();
    end
    xfer(1'b1, seq_decode_pkg::OFS_STATUS, 32'hFFFF_FFFF);
    rd(8'h40, 32'h0, 32'hFFFF_FFFF);
    check();
    final_report();
  end
endmodule // sequencer_instruction_decode_test
